// ### logic/ssq_defines.vh
`ifndef SSQ_DEFINES_VH
`define SSQ_DEFINES_VH

// register byte offsets on the AHB-Lite slave
`define SSQ_REG_CTRL 8'h00
`define SSQ_REG_STAT 8'h04
`define SSQ_REG_CNT 8'h08

// control register field positions and reset value
`define SSQ_CTRL_TAGGED 0
`define SSQ_CTRL_ASR 1
`define SSQ_CTRL_LINK 2
`define SSQ_CTRL_RST 3'h0

// status byte code field values (placed in bits 6..1)
`define SSQ_CODE_GOOD 6'h00
`define SSQ_CODE_CHECK 6'h01
`define SSQ_CODE_MET 6'h02
`define SSQ_CODE_BUSY 6'h04
`define SSQ_CODE_INTER 6'h08
`define SSQ_CODE_INTER_MET 6'h0A
`define SSQ_CODE_RESV 6'h0C
`define SSQ_CODE_TSF 6'h14
`define SSQ_CODE_ACA 6'h18
`define SSQ_CODE_ABORTED 6'h20

// message bytes sent in message in phase
`define SSQ_MSG_CMD_CPL 8'h00
`define SSQ_MSG_SAVE_PTR 8'h02
`define SSQ_MSG_DISC 8'h04
`define SSQ_MSG_LINK_CPL 8'h0A

// default task set depth
`define SSQ_QDEPTH 8'h10

`endif

// ### logic/ssq_sync.v
`timescale 1ns/1ps
// two flop synchroniser for pin inputs
module ssq_sync #(
   parameter W = 1
) (
   input wire ref_clk,
   input wire nrst,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // first stage feeds only the second stage
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule // ssq_sync

// ### logic/ssq_status_sequencer.v
// Implementation choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "ssq_defines.vh"
// Notes on behaviour
// - one status byte per ended command unless cancelled by abort or reset
// - good (00h) when the task finished successfully
// - check condition (02h) when an allegiance condition arises
// - condition met (04h) when an unlinked operation is satisfied
// - busy (08h) when the unit cannot accept a conflict-free command
// - linked commands except the last return 10h or 14h on success
// - 14h instead of 10h when a linked operation is satisfied
// - reservation conflict (18h) on access under another's reservation
// - task set full only when tagged tasks are supported
// - task set full when resources short and initiator already has a task
// - busy when resources short for a tagged task of a taskless initiator
// - busy when set non-empty and an untagged task cannot enter
// - keep one queue slot for each identified initiator without a task
// - allegiance active (30h) under the three allegiance conditions
// - task aborted (40h) only when the aborted status report bit is one
// - busy, conflict, allegiance active, set full win over other status
// - after data: status byte, command complete message, then bus free
// - long delay: disconnect message, release busy, bus goes free
// - after disconnect, arbitrate and reselect when data is ready
// - mid-transfer disconnect sends save pointer message first
module ssq_status_sequencer #(
   parameter QDEPTH = `SSQ_QDEPTH
) (
   input wire ref_clk,
   input wire nrst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire cmd_start,
   input wire cancel,
   input wire disc_req,
   input wire mid_xfer,
   input wire data_ready,
   input wire end_valid,
   input wire f_check,
   input wire f_cond_met,
   input wire f_lu_busy,
   input wire f_resv_conflict,
   input wire f_aca_exists,
   input wire f_aca_task_present,
   input wire f_issuer_faulted,
   input wire f_new_task_aca,
   input wire f_faulting_allegiance_control_bit,
   input wire f_aborted_other,
   input wire f_linked,
   input wire f_tagged,
   input wire f_init_has_task,
   input wire f_new_task,
   input wire task_enter,
   input wire task_leave,
   input wire [3:0] idle_inits,
   input wire ack_pin,
   input wire rst_pin,
   input wire arb_won_pin,
   input wire resel_bsy_pin,
   output reg bsy_o,
   output reg sel_o,
   output reg req_o,
   output reg cd_o,
   output reg io_o,
   output reg msg_o,
   output reg [7:0] data_o,
   output reg data_oe_n,
   output reg status_sent
);
   localparam ST_IDLE = 10'h001;
   localparam ST_XFER = 10'h002;
   localparam ST_SDP = 10'h004;
   localparam ST_DISC = 10'h008;
   localparam ST_WAIT = 10'h010;
   localparam ST_ARB = 10'h020;
   localparam ST_RESEL = 10'h040;
   localparam ST_STAT = 10'h080;
   localparam ST_CPL = 10'h100;
   localparam ST_FREE = 10'h200;
   wire ack_s;
   wire rst_s;
   wire arb_s;
   wire rbsy_s;
   reg [9:0] state_ff;
   reg [1:0] hs_ff;
   reg [7:0] stat_ff;
   reg inter_ff;
   reg [2:0] ctrl_ff;
   reg [7:0] task_cnt_ff;
   reg [15:0] sent_cnt_ff;
   reg wr_pend_ff;
   reg [7:0] wr_addr_ff;
   reg [5:0] nxt_code;
   reg nxt_inter;
   reg res_short;
   reg [7:0] tx_byte;
   reg [31:0] rd_mux;
   // pin inputs pass two flops first
   ssq_sync #(.W(4)) u_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d({ack_pin, rst_pin, arb_won_pin, resel_bsy_pin}),
      .q({ack_s, rst_s, arb_s, rbsy_s})
   );
   // slots held back for identified initiators without a task
   wire [8:0] used_sum = {1'b0, task_cnt_ff} + {5'h00, idle_inits};
   // resource shortage for the arriving task
   always @* begin
      res_short = 1'b0;
      if (f_new_task) begin
         if (f_init_has_task) begin
            res_short = (used_sum >= {1'b0, QDEPTH[7:0]});
         end else begin
            res_short = (task_cnt_ff >= QDEPTH[7:0]);
         end
      end
   end
   // status code selection with precedence
   always @* begin
      nxt_code = `SSQ_CODE_GOOD;
      nxt_inter = 1'b0;
      if (f_resv_conflict) begin
         nxt_code = `SSQ_CODE_RESV;
      end else if (f_aca_exists && (f_aca_task_present || !f_issuer_faulted
                   || (!f_new_task_aca && f_faulting_allegiance_control_bit))) begin
         nxt_code = `SSQ_CODE_ACA;
      end else if (res_short && f_tagged && f_init_has_task
                   && ctrl_ff[`SSQ_CTRL_TAGGED]) begin
         nxt_code = `SSQ_CODE_TSF;
      end else if (f_lu_busy || res_short) begin
         nxt_code = `SSQ_CODE_BUSY;
      end else if (f_check) begin
         nxt_code = `SSQ_CODE_CHECK;
      end else if (f_aborted_other && ctrl_ff[`SSQ_CTRL_ASR]) begin
         nxt_code = `SSQ_CODE_ABORTED;
      end else if (f_linked && !ctrl_ff[`SSQ_CTRL_LINK]) begin
         nxt_code = `SSQ_CODE_CHECK;
      end else if (f_linked) begin
         nxt_inter = 1'b1;
         if (f_cond_met) begin
            nxt_code = `SSQ_CODE_INTER_MET;
         end else begin
            nxt_code = `SSQ_CODE_INTER;
         end
      end else if (f_cond_met) begin
         nxt_code = `SSQ_CODE_MET;
      end
   end
   // byte offered in each sending state
   always @* begin
      case (state_ff)
         ST_SDP: tx_byte = `SSQ_MSG_SAVE_PTR;
         ST_DISC: tx_byte = `SSQ_MSG_DISC;
         ST_STAT: tx_byte = stat_ff;
         ST_CPL: tx_byte = inter_ff ? `SSQ_MSG_LINK_CPL : `SSQ_MSG_CMD_CPL;
         default: tx_byte = 8'h00;
      endcase
   end
   // a byte is done once the synchronised ack has fallen again
   wire byte_done = (hs_ff == 2'h2) && !ack_s;
   // task set occupancy
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         task_cnt_ff <= 8'h00;
      end else if (rst_s) begin
         task_cnt_ff <= 8'h00;
      end else if (task_enter && !task_leave
                   && task_cnt_ff != QDEPTH[7:0]) begin
         task_cnt_ff <= task_cnt_ff + 8'h01;
      end else if (task_leave && !task_enter && task_cnt_ff != 8'h00) begin
         task_cnt_ff <= task_cnt_ff - 8'h01;
      end
   end
   // bus phase sequencer
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         hs_ff <= 2'h0;
         stat_ff <= 8'h00;
         inter_ff <= 1'b0;
         bsy_o <= 1'b0;
         sel_o <= 1'b0;
         req_o <= 1'b0;
         cd_o <= 1'b0;
         io_o <= 1'b0;
         msg_o <= 1'b0;
         data_o <= 8'h00;
         data_oe_n <= 1'b1;
         status_sent <= 1'b0;
         sent_cnt_ff <= 16'h0000;
      end else begin
         status_sent <= 1'b0;
         if (rst_s || cancel) begin
            // cancelled command: bus released, no status byte
            state_ff <= ST_IDLE;
            hs_ff <= 2'h0;
            bsy_o <= 1'b0;
            sel_o <= 1'b0;
            req_o <= 1'b0;
            cd_o <= 1'b0;
            io_o <= 1'b0;
            msg_o <= 1'b0;
            data_oe_n <= 1'b1;
         end else begin
            // byte handshake shared by message and status states
            if (state_ff == ST_SDP || state_ff == ST_DISC
                || state_ff == ST_STAT || state_ff == ST_CPL) begin
               case (hs_ff)
                  2'h0: begin
                     data_o <= tx_byte;
                     data_oe_n <= 1'b0;
                     req_o <= 1'b1;
                     hs_ff <= 2'h1;
                  end
                  2'h1: begin
                     if (ack_s) begin
                        req_o <= 1'b0;
                        hs_ff <= 2'h2;
                     end
                  end
                  2'h2: begin
                     if (!ack_s) begin
                        hs_ff <= 2'h0;
                     end
                  end
                  default: hs_ff <= 2'h0;
               endcase
            end
            case (state_ff)
               ST_IDLE: begin
                  // initiator has selected us and sent the command
                  if (cmd_start) begin
                     state_ff <= ST_XFER;
                     bsy_o <= 1'b1;
                  end
               end
               ST_XFER: begin
                  cd_o <= 1'b0;
                  msg_o <= 1'b0;
                  data_oe_n <= 1'b1;
                  if (end_valid) begin
                     stat_ff <= {1'b0, nxt_code, 1'b0};
                     inter_ff <= nxt_inter;
                     cd_o <= 1'b1;
                     io_o <= 1'b1;
                     state_ff <= ST_STAT;
                  end else if (disc_req) begin
                     cd_o <= 1'b1;
                     io_o <= 1'b1;
                     msg_o <= 1'b1;
                     if (mid_xfer) begin
                        state_ff <= ST_SDP;
                     end else begin
                        state_ff <= ST_DISC;
                     end
                  end
               end
               ST_SDP: begin
                  if (byte_done) begin
                     state_ff <= ST_DISC;
                  end
               end
               ST_DISC: begin
                  if (byte_done) begin
                     state_ff <= ST_WAIT;
                     bsy_o <= 1'b0;
                     cd_o <= 1'b0;
                     io_o <= 1'b0;
                     msg_o <= 1'b0;
                     data_oe_n <= 1'b1;
                  end
               end
               ST_WAIT: begin
                  if (data_ready) begin
                     state_ff <= ST_ARB;
                     bsy_o <= 1'b1;
                  end
               end
               ST_ARB: begin
                  if (arb_s) begin
                     state_ff <= ST_RESEL;
                     sel_o <= 1'b1;
                     io_o <= 1'b1;
                  end
               end
               ST_RESEL: begin
                  // initiator answers reselection with its busy
                  if (rbsy_s) begin
                     sel_o <= 1'b0;
                     state_ff <= ST_XFER;
                  end
               end
               ST_STAT: begin
                  if (byte_done) begin
                     status_sent <= 1'b1;
                     sent_cnt_ff <= sent_cnt_ff + 16'h0001;
                     msg_o <= 1'b1;
                     state_ff <= ST_CPL;
                  end
               end
               ST_CPL: begin
                  if (byte_done) begin
                     if (inter_ff) begin
                        state_ff <= ST_XFER;
                     end else begin
                        state_ff <= ST_FREE;
                     end
                  end
               end
               ST_FREE: begin
                  bsy_o <= 1'b0;
                  cd_o <= 1'b0;
                  io_o <= 1'b0;
                  msg_o <= 1'b0;
                  data_oe_n <= 1'b1;
                  state_ff <= ST_IDLE;
               end
               default: state_ff <= ST_IDLE;
            endcase
         end
      end
   end
   // register read mux, upper address bits not decoded
   always @* begin
      case (haddr[7:0])
         `SSQ_REG_CTRL: rd_mux = {29'h0, ctrl_ff};
         `SSQ_REG_STAT: rd_mux = {6'h00, state_ff, task_cnt_ff, stat_ff};
         `SSQ_REG_CNT: rd_mux = {16'h0000, sent_cnt_ff};
         default: rd_mux = 32'h00000000;
      endcase
   end
   // ahb-lite slave, zero wait states, always okay
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         ctrl_ff <= `SSQ_CTRL_RST;
      end else begin
         wr_pend_ff <= 1'b0;
         if (hsel && hready && htrans[1]) begin
            if (hwrite) begin
               wr_pend_ff <= 1'b1;
               wr_addr_ff <= haddr[7:0];
            end else begin
               hrdata <= rd_mux;
            end
         end
         if (wr_pend_ff && wr_addr_ff == `SSQ_REG_CTRL) begin
            ctrl_ff <= hwdata[2:0];
         end
      end
   end
endmodule // ssq_status_sequencer

// ### tb/ssq_chk.sv
`timescale 1ns/1ps
// bus-side protocol checks on the target's outputs
module ssq_chk (
   input wire ref_clk,
   input wire nrst,
   input wire end_valid,
   input wire cancel,
   input wire ack_pin,
   input wire bsy_o,
   input wire sel_o,
   input wire req_o,
   input wire cd_o,
   input wire io_o,
   input wire msg_o,
   input wire [7:0] data_o,
   input wire data_oe_n,
   input wire status_sent
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // status phase byte on offer
   wire st_ph = req_o && cd_o && io_o && !msg_o;
   code_fields_a:
      assert property (st_ph |-> !data_o[7] && !data_o[0] &&
         (!data_o[6] || data_o == 8'h40))
      else $error("reserved status bits set");
   code_set_a:
      assert property (st_ph |-> data_o inside {8'h00, 8'h02, 8'h04, 8'h08,
         8'h10, 8'h14, 8'h18, 8'h28, 8'h30, 8'h40})
      else $error("undefined status code");
   req_drive_a:
      assert property (req_o |-> !data_oe_n && bsy_o)
      else $error("byte offered without driving");
   req_hold_a:
      assert property (req_o && !ack_pin && !cancel |=> req_o && $stable(data_o))
      else $error("byte withdrawn before ack");
   ack_drop_a:
      assert property ($rose(ack_pin) && req_o && !cancel |-> ##[1:4] !req_o)
      else $error("req not dropped after ack");
   end_answer_a:
      assert property (end_valid && bsy_o && !sel_o && !cd_o && !msg_o &&
         !cancel |=> cd_o && io_o ##1 (req_o || $past(cancel)))
      else $error("no status phase after command end");
   sent_msg_a:
      assert property (status_sent |-> ##[0:2] (msg_o && cd_o && io_o))
      else $error("no message after status");
   free_rel_a:
      assert property ($fell(bsy_o) |-> !req_o && !sel_o && data_oe_n)
      else $error("bus not released at bus free");
   resel_a:
      assert property ($rose(sel_o) |-> bsy_o && io_o && !req_o)
      else $error("bad reselection phase");
endmodule // ssq_chk
bind ssq_status_sequencer ssq_chk u_chk (.ref_clk, .nrst, .end_valid,
   .cancel, .ack_pin, .bsy_o, .sel_o, .req_o, .cd_o, .io_o, .msg_o, .data_o,
   .data_oe_n, .status_sent);

// ### tb/ssq_init_model.sv
`timescale 1ns/1ps
// initiator on the far side of the bus
module ssq_init_model (
   input wire ref_clk,
   input wire nrst,
   input wire [3:0] dly,
   input wire bsy_o,
   input wire sel_o,
   input wire req_o,
   input wire cd_o,
   input wire io_o,
   input wire msg_o,
   input wire [7:0] data_o,
   output logic ack_pin,
   output logic arb_won_pin,
   output logic resel_bsy_pin
);
   logic [10:0] got[$];
   logic disc_seen = 0;
   logic freed = 0;
   int act_ptr = 0;
   int sav_ptr = 0;
   initial begin
      ack_pin = 0;
      arb_won_pin = 0;
      resel_bsy_pin = 0;
   end
   // take one byte per req/ack after dly cycles; a dropped req is not acked
   always @(posedge ref_clk) begin
      if (nrst && req_o && !ack_pin) begin
         repeat (dly) @(posedge ref_clk);
         if (req_o) begin
            got.push_back({msg_o, cd_o, io_o, data_o});
            if (msg_o && data_o == 8'h02) sav_ptr <= act_ptr;
            ack_pin <= 1;
            while (req_o) @(posedge ref_clk);
            repeat (dly) @(posedge ref_clk);
            ack_pin <= 0;
         end
      end
   end
   // grant arbitration only after a disconnect freed the bus
   always @(posedge ref_clk) begin
      if (req_o && ack_pin && msg_o && data_o == 8'h04) disc_seen <= 1;
      if (disc_seen && !bsy_o) freed <= 1;
      arb_won_pin <= nrst && freed && bsy_o && !sel_o;
      resel_bsy_pin <= nrst && sel_o && io_o;
      if (sel_o) disc_seen <= 0;
      if (sel_o) freed <= 0;
      if (sel_o) act_ptr <= sav_ptr;
   end
endmodule // ssq_init_model

// ### tb/scsi_target_status_sequencer_tb.sv
`timescale 1ns/1ps
`include "ssq_defines.vh"
module scsi_target_status_sequencer_tb;
   localparam int QD = 4;
   logic ref_clk = 0, nrst = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0] htrans = 0;
   logic cmd_start = 0, cancel = 0, disc_req = 0, mid_xfer = 0;
   logic data_ready = 0, end_valid = 0, task_enter = 0, task_leave = 0;
   logic [13:0] fl = 0, f;
   logic [3:0] idle = 0, dly = 2;
   logic [2:0] ctrl = 0;
   logic rpin = 0;
   logic [7:0] last_e;
   wire [31:0] hrdata;
   wire [7:0] data_o;
   wire hreadyout, hresp, ack, arb, resb, bsy_o, sel_o, req_o, cd_o, io_o;
   wire msg_o, oe_n, sent;
   int miscompares = 0, num_checks = 0, tcnt = 0, scnt = 0;
   logic [13:0] dir[15] = '{14'h0000, 14'h2000, 14'h1000, 14'h0800,
      14'h0400, 14'h0008, 14'h1008, 14'h0010, 14'h0380, 14'h0200, 14'h02A0,
      14'h02C0, 14'h2C00, 14'h2800, 14'h2210};
   always #25 ref_clk = ~ref_clk;
   ssq_status_sequencer #(.QDEPTH(QD)) DUT (
      .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cmd_start(cmd_start), .cancel(cancel),
      .disc_req(disc_req), .mid_xfer(mid_xfer), .data_ready(data_ready),
      .end_valid(end_valid), .f_check(fl[13]), .f_cond_met(fl[12]),
      .f_lu_busy(fl[11]), .f_resv_conflict(fl[10]), .f_aca_exists(fl[9]),
      .f_aca_task_present(fl[8]), .f_issuer_faulted(fl[7]),
      .f_new_task_aca(fl[6]), .f_faulting_allegiance_control_bit(fl[5]),
      .f_aborted_other(fl[4]), .f_linked(fl[3]), .f_tagged(fl[2]),
      .f_init_has_task(fl[1]), .f_new_task(fl[0]),
      .task_enter(task_enter), .task_leave(task_leave), .idle_inits(idle),
      .ack_pin(ack), .rst_pin(rpin), .arb_won_pin(arb),
      .resel_bsy_pin(resb), .bsy_o(bsy_o), .sel_o(sel_o), .req_o(req_o),
      .cd_o(cd_o), .io_o(io_o), .msg_o(msg_o), .data_o(data_o),
      .data_oe_n(oe_n), .status_sent(sent));
   ssq_init_model pm (.ref_clk(ref_clk), .nrst(nrst), .dly(dly),
      .bsy_o(bsy_o), .sel_o(sel_o), .req_o(req_o), .cd_o(cd_o), .io_o(io_o),
      .msg_o(msg_o), .data_o(data_o), .ack_pin(ack), .arb_won_pin(arb),
      .resel_bsy_pin(resb));
   task automatic stop_test();
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // single word transfer, held until hready is seen high
   task automatic ahb(input logic w, input logic [7:0] a, input int d);
      @(posedge ref_clk);
      hsel <= 1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // poll the state field until it reaches s
   task automatic wst(input logic [9:0] s);
      int n;
      n = 0;
      do begin
         ahb(0, `SSQ_REG_STAT, 0);
         n++;
      end while (rd[25:16] !== s && n < 300);
      chk(rd[25:16], s);
   endtask
   task automatic setc(input logic [2:0] c);
      ctrl = c;
      ahb(1, `SSQ_REG_CTRL, c);
   endtask
   task automatic tsk(input logic e, input logic l);
      @(posedge ref_clk);
      task_enter <= e;
      task_leave <= l;
      @(posedge ref_clk);
      task_enter <= 0;
      task_leave <= 0;
      if (e && !l && tcnt < QD) tcnt++;
      if (l && !e && tcnt > 0) tcnt--;
   endtask
   // reference status byte with the chosen precedence
   function automatic logic [7:0] model(input logic [13:0] f);
      logic [5:0] c;
      logic sh;
      sh = f[0] && tcnt + (f[1] ? idle : 0) >= QD;
      if (f[10]) c = `SSQ_CODE_RESV;
      else if (f[9] && (f[8] || !f[7] || (!f[6] && f[5]))) c = `SSQ_CODE_ACA;
      else if (sh && f[2] && f[1] && ctrl[0]) c = `SSQ_CODE_TSF;
      else if (sh || f[11]) c = `SSQ_CODE_BUSY;
      else if (f[13]) c = `SSQ_CODE_CHECK;
      else if (f[4] && ctrl[1]) c = `SSQ_CODE_ABORTED;
      else if (f[3] && !ctrl[2]) c = `SSQ_CODE_CHECK;
      else if (f[3]) c = f[12] ? `SSQ_CODE_INTER_MET : `SSQ_CODE_INTER;
      else if (f[12]) c = `SSQ_CODE_MET;
      else c = `SSQ_CODE_GOOD;
      return {1'b0, c, 1'b0};
   endfunction
   function automatic logic inter();
      return last_e == 8'h10 || last_e == 8'h14;
   endfunction
   function automatic logic [10:0] pop();
      return pm.got.size() > 0 ? pm.got.pop_front() : 11'h7FF;
   endfunction
   task automatic go();
      @(posedge ref_clk);
      cmd_start <= 1;
      @(posedge ref_clk);
      cmd_start <= 0;
   endtask
   // end the command and check status byte, message and final state
   task automatic fin(input logic [13:0] f);
      int n;
      last_e = model(f);
      @(posedge ref_clk);
      fl <= f;
      end_valid <= 1;
      @(posedge ref_clk);
      end_valid <= 0;
      for (n = 0; n < 3000 && pm.got.size() < 2; n++) @(posedge ref_clk);
      chk(pop(), {3'b011, last_e});
      chk(pop(), {3'b111, inter() ? 8'h0A : 8'h00});
      scnt++;
      wst(inter() ? 10'h002 : 10'h001);
      chk(rd[7:0], last_e);
   endtask
   task automatic cmd(input logic [13:0] f);
      go();
      fin(f);
      while (inter()) fin(f & 14'h3FF7);
   endtask
   initial begin
      repeat (80000) @(posedge ref_clk);
      miscompares++;
      stop_test();
   end
   initial begin
      rd = $urandom(67581);
      repeat (6) @(posedge ref_clk);
      nrst <= 1;
      ahb(0, `SSQ_REG_CTRL, 0);
      chk(rd, 0);
      ahb(1, `SSQ_REG_CTRL, -1);
      ahb(0, `SSQ_REG_CTRL, 0);
      chk(rd, 7);
      ahb(1, `SSQ_REG_CNT, 5);
      ahb(0, `SSQ_REG_CNT, 0);
      chk(rd, 0);
      ahb(0, 8'h0C, 0);
      chk(rd, 0);
      foreach (dir[i]) for (int c = 0; c < 2; c++) begin
         setc(c ? 3'h7 : 3'h0);
         cmd(dir[i]);
      end
      // task set resource shortage
      for (int i = 0; i < QD + 2; i++) tsk(1, 0);
      tsk(1, 1);
      ahb(0, `SSQ_REG_STAT, 0);
      chk(rd[15:8], tcnt);
      setc(3'h7);
      cmd(14'h0007);
      cmd(14'h0005);
      cmd(14'h0003);
      setc(3'h6);
      cmd(14'h0007);
      for (int i = 0; i < QD + 1; i++) tsk(0, 1);
      repeat (QD - 1) tsk(1, 0);
      idle <= 1;
      setc(3'h7);
      cmd(14'h0007);
      idle <= 0;
      // hard reset pin while idle empties the task set
      rpin <= 1;
      repeat (4) @(posedge ref_clk);
      rpin <= 0;
      tcnt = 0;
      wst(10'h001);
      chk(rd[15:8], tcnt);
      // disconnect, with and without a saved pointer
      for (int m = 0; m < 2; m++) begin
         go();
         @(posedge ref_clk);
         disc_req <= 1;
         mid_xfer <= m[0];
         @(posedge ref_clk);
         disc_req <= 0;
         wst(10'h010);
         if (m) chk(pop(), {3'b111, `SSQ_MSG_SAVE_PTR});
         chk(pop(), {3'b111, `SSQ_MSG_DISC});
         data_ready <= 1;
         wst(10'h002);
         data_ready <= 0;
         fin(14'h1000);
      end
      // cancel just after the command ends: no status
      dly <= 8;
      go();
      @(posedge ref_clk);
      end_valid <= 1;
      @(posedge ref_clk);
      end_valid <= 0;
      cancel <= 1;
      @(posedge ref_clk);
      cancel <= 0;
      wst(10'h001);
      chk(pm.got.size(), 0);
      for (int k = 0; k < 40; k++) begin
         setc(3'($urandom));
         dly <= 4'($urandom % 6);
         tsk(1'($urandom), 1'($urandom));
         f = 14'($urandom);
         if (f[4]) f = f & 14'h2FF7;
         cmd(f);
      end
      ahb(0, `SSQ_REG_CNT, 0);
      chk(rd, scnt);
      stop_test();
   end
endmodule // scsi_target_status_sequencer_tb
